// ==== pics_addr_form.sv ====
`timescale 1ns/1ns
module pics_addr_form
    import pics_pkg::*;
(
    input wire logic [7:0] pixel_i, // Pixel-derived address
    input wire logic [7:0] mask_i, // Plane mask
    input wire logic [7:0] page_i, // Page register
    input wire logic [1:0] planes_i, // Plane count code
    input wire logic masked_i, // Mask applies (pseudo/VGA)
    output logic [7:0] addr_o // Palette address
);
    // =========================================================
    // Mask first, then page bits
    logic [7:0] masked;
    logic [7:0] keep;
    assign masked = masked_i ? (pixel_i & mask_i) : pixel_i;
    assign keep = (planes_i == PLANES_4) ? 8'h0f :
                  (planes_i == PLANES_2) ? 8'h3f :
                  (planes_i == PLANES_1) ? 8'h7f : 8'hff;
    assign addr_o = (masked & keep) | (page_i & ~keep);
endmodule // pics_addr_form

// ==== pics_colour_bank.sv ====
`timescale 1ns/1ns
module pics_colour_bank
    import pics_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Async reset
    input wire logic ce_i, // Clock enable
    input wire logic ptr_wr_i, // Pointer written
    input wire logic [1:0] ptr_val_i, // New pointer
    input wire logic data_wr_i, // Data port write
    input wire logic data_rd_i, // Data port read
    input wire logic [7:0] wdata_i, // Write byte
    output logic [7:0] rdata_o, // Current read byte
    output logic [1:0] ptr_o, // Current colour pointer
    output logic [95:0] colours_o // Four 24-bit colours
);
    // =========================================================
    // Byte phase 0..2 = red, green, blue
    logic [1:0] phase_reg;
    logic [1:0] ptr_reg;
    logic [23:0] col_reg [4];
    logic step;
    // Top bit of the byte lane for a phase: red 23, green 15, blue 7
    function automatic logic [4:0] byte_top(input logic [1:0] ph);
        return 5'd23 - {ph, 3'b000};
    endfunction
    assign step = (data_wr_i | data_rd_i) && phase_reg == 2'h2;
    assign rdata_o = col_reg[ptr_reg][byte_top(phase_reg) -: 8];
    assign ptr_o = ptr_reg;
    assign colours_o = {col_reg[3], col_reg[2], col_reg[1], col_reg[0]};
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_reg <= 2'h0;
            ptr_reg <= 2'h0;
            for (int i = 0; i < 4; i++) col_reg[i] <= 24'h0;
        end else if (ce_i) begin
            if (ptr_wr_i) begin
                ptr_reg <= ptr_val_i;
                phase_reg <= 2'h0;
            end else if (data_wr_i | data_rd_i) begin
                if (data_wr_i)
                    col_reg[ptr_reg][byte_top(phase_reg) -: 8] <= wdata_i;
                phase_reg <= step ? 2'h0 : phase_reg + 2'h1;
                if (step) ptr_reg <= ptr_reg + 2'h1;
            end
        end
    end
endmodule // pics_colour_bank

// ==== pics_host.sv ====
`timescale 1ns/1ns
module pics_host (
    input wire logic clk_i, // Clock
    input wire logic [7:0] rdata_i, // Read data
    output logic [3:0] sel_o, // Register select
    output logic wr_o, // Write strobe
    output logic rd_o, // Read strobe
    output logic [7:0] wdata_o // Write data
);
    // ==========================================
    // Strobes span 4 cycles each way to clear the pin synchroniser
    initial begin
        sel_o = 4'h6;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    task automatic wr(input logic [3:0] s, input logic [7:0] d);
        sel_o = s;
        wdata_o = d;
        wr_o = 1'b1;
        repeat (4) @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
        repeat (4) @(negedge clk_i);
    endtask
    task automatic rd(input logic [3:0] s, output logic [7:0] d);
        sel_o = s;
        rd_o = 1'b1;
        repeat (4) @(negedge clk_i);
        d = rdata_i;
        rd_o = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask
endmodule // pics_host

// ==== pics_pkg.sv ====
package pics_pkg;
    // =========================================================
    // Direct register selects
    localparam logic [3:0] SEL_PLANE_MASK = 4'h2;
    localparam logic [3:0] SEL_COLOUR_WPTR = 4'h4;
    localparam logic [3:0] SEL_COLOUR_PORT = 4'h5;
    localparam logic [3:0] SEL_COLOUR_RPTR = 4'h7;
    localparam logic [3:0] SEL_INDEX_ADDR = 4'h0;
    localparam logic [3:0] SEL_INDEX_DATA = 4'ha;
    // =========================================================
    // Indexed registers
    localparam logic [7:0] IDX_CLOCK_SOURCE = 8'h1a;
    localparam logic [7:0] IDX_LOOKUP_PAGE = 8'h1c;
    // =========================================================
    // Reset values
    localparam logic [7:0] RST_PLANE_MASK = 8'hff;
    localparam logic [7:0] RST_CLOCK_SOURCE = 8'h07;
    localparam logic [7:0] RST_LOOKUP_PAGE = 8'h00;
    // =========================================================
    // Dot clock source codes
    localparam logic [3:0] CSRC_PRI_LATCH = 4'h0;
    localparam logic [3:0] CSRC_SYNTH = 4'h5;
    localparam logic [3:0] CSRC_STOP = 4'h6;
    localparam logic [3:0] CSRC_PRI_PRI = 4'h7;
    // =========================================================
    // Plane count codes
    localparam logic [1:0] PLANES_8 = 2'h0;
    localparam logic [1:0] PLANES_4 = 2'h1;
    localparam logic [1:0] PLANES_2 = 2'h2;
    localparam logic [1:0] PLANES_1 = 2'h3;
    // =========================================================
    // Clock path output selects
    typedef enum logic [1:0] {
        DCLK_STOP = 2'h0,
        DCLK_PRIMARY = 2'h1,
        DCLK_SYNTH = 2'h2
    } pics_dclk_t;
endpackage

// ==== pics_regs.sv ====
`timescale 1ns/1ns
// Functional notes
// - Mask ANDs pixel address bits
// - Zero mask bit blocks plane
// - Page bits inserted after masking
// - Few planes take upper bits from page
// - Narrow overlay filled from page
// - Write pointer picks colour register
// - Colours loaded red, green, blue bytes
// - Pointer advances after blue write
// - Read pointer, three reads, then advance
// - Pointer wraps through four colours
// - Twelve accesses cover all colours
// - Clock source resets to 0x07
// - Code 111 latches port on primary
// - Code 000 latches port on latch clock
// - Code 0101 selects synthesizer clock
// - Code 0110 stops dot clock
module pics_regs
    import pics_pkg::*;
(
    input wire logic MCLK_I, // Clock
    input wire logic RST_I, // Async reset, high
    input wire logic CE_I, // Clock enable
    input wire logic [3:0] SEL_I, // Direct register select pins
    input wire logic WR_I, // Write strobe (async pin)
    input wire logic RD_I, // Read strobe (async pin)
    input wire logic [7:0] WDATA_I, // Write data
    input wire logic [7:0] PIXEL_I, // Pixel-derived address
    input wire logic [1:0] PLANES_I, // Plane count code
    input wire logic MASK_EN_I, // Pseudo-color or VGA mode
    input wire logic LATCH_SEL_I, // Legacy port latch select
    output logic [7:0] RDATA_O, // Read data
    output logic [7:0] PAL_ADDR_O, // Palette address
    output logic [95:0] COLOURS_O, // Overscan and cursor colours
    output logic [1:0] DCLK_SEL_O, // Dot clock source
    output logic LATCH_ON_LATCH_CLOCK_INPUT_O, // Latch port on latch clock
    output logic SYS_BLANK_SEL_O // Use system blank input
);
    // =========================================================
    // Strobe synchronisers and edge detect
    logic [1:0] wr_sync_reg, rd_sync_reg;
    logic wr_d_reg, rd_d_reg;
    logic wr_p, rd_p;
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            wr_sync_reg <= 2'h0;
            rd_sync_reg <= 2'h0;
            wr_d_reg <= 1'b0;
            rd_d_reg <= 1'b0;
        end else if (CE_I) begin
            wr_sync_reg <= {wr_sync_reg[0], WR_I};
            rd_sync_reg <= {rd_sync_reg[0], RD_I};
            wr_d_reg <= wr_sync_reg[1];
            rd_d_reg <= rd_sync_reg[1];
        end
    end
    assign wr_p = wr_sync_reg[1] & ~wr_d_reg;
    // Read advances on strobe end so the byte held stays valid meanwhile
    assign rd_p = ~rd_sync_reg[1] & rd_d_reg;
    // =========================================================
    // Register decode
    logic [7:0] mask_reg, page_reg, index_reg, csrc_reg;
    logic [3:0] sel;
    assign sel = SEL_I;
    logic wr_mask, wr_wptr, wr_rptr, wr_port, rd_port, wr_idx, wr_ind;
    assign wr_mask = wr_p && sel == SEL_PLANE_MASK;
    assign wr_wptr = wr_p && sel == SEL_COLOUR_WPTR;
    assign wr_rptr = wr_p && sel == SEL_COLOUR_RPTR;
    assign wr_port = wr_p && sel == SEL_COLOUR_PORT;
    assign rd_port = rd_p && sel == SEL_COLOUR_PORT;
    assign wr_idx = wr_p && sel == SEL_INDEX_ADDR;
    assign wr_ind = wr_p && sel == SEL_INDEX_DATA;
    logic [7:0] wptr_reg, rptr_reg;
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            mask_reg <= RST_PLANE_MASK;
            page_reg <= RST_LOOKUP_PAGE;
            index_reg <= 8'h00;
            csrc_reg <= RST_CLOCK_SOURCE;
            wptr_reg <= 8'h00;
            rptr_reg <= 8'h00;
        end else if (CE_I) begin
            if (wr_mask) mask_reg <= WDATA_I;
            if (wr_idx) index_reg <= WDATA_I;
            if (wr_wptr) wptr_reg <= WDATA_I;
            if (wr_rptr) rptr_reg <= WDATA_I;
            if (wr_ind && index_reg == IDX_LOOKUP_PAGE) page_reg <= WDATA_I;
            if (wr_ind && index_reg == IDX_CLOCK_SOURCE) csrc_reg <= WDATA_I;
        end
    end
    // =========================================================
    // Colour bank
    logic [7:0] col_byte;
    logic [1:0] col_ptr;
    logic [95:0] colours;
    pics_colour_bank u_bank (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .ce_i(CE_I),
        .ptr_wr_i(wr_wptr | wr_rptr),
        .ptr_val_i(WDATA_I[1:0]),
        .data_wr_i(wr_port),
        .data_rd_i(rd_port),
        .wdata_i(WDATA_I),
        .rdata_o(col_byte),
        .ptr_o(col_ptr),
        .colours_o(colours)
    );
    // =========================================================
    // Palette address
    logic [7:0] pal_addr;
    pics_addr_form u_addr (
        .pixel_i(PIXEL_I),
        .mask_i(mask_reg),
        .page_i(page_reg),
        .planes_i(PLANES_I),
        .masked_i(MASK_EN_I),
        .addr_o(pal_addr)
    );
    // =========================================================
    // Dot clock source; reserved codes hold the last valid choice
    logic [3:0] code;
    logic valid_code;
    assign code = csrc_reg[3:0];
    assign valid_code = code == CSRC_PRI_LATCH || code == CSRC_PRI_PRI ||
                        code == CSRC_SYNTH || code == CSRC_STOP;
    pics_dclk_t dclk_next;
    assign dclk_next = (code == CSRC_SYNTH) ? DCLK_SYNTH :
                       (code == CSRC_STOP) ? DCLK_STOP :
                       DCLK_PRIMARY;
    // Codes 000 and 111 set the latch select; codes 0101 and 0110 follow LATCH_SEL_I as given
    logic latch_clock_input_next;
    assign latch_clock_input_next = (code == CSRC_PRI_LATCH) ? 1'b1 :
                       (code == CSRC_PRI_PRI) ? 1'b0 :
                       LATCH_SEL_I;
    logic [7:0] rdata_next;
    assign rdata_next = (sel == SEL_PLANE_MASK) ? mask_reg :
                        (sel == SEL_COLOUR_WPTR) ? wptr_reg :
                        (sel == SEL_COLOUR_RPTR) ? rptr_reg :
                        (sel == SEL_COLOUR_PORT) ? col_byte :
                        (sel == SEL_INDEX_ADDR) ? index_reg :
                        (sel == SEL_INDEX_DATA) ?
                            ((index_reg == IDX_LOOKUP_PAGE) ? page_reg :
                             (index_reg == IDX_CLOCK_SOURCE) ? csrc_reg :
                             8'h00) : 8'h00;
    // =========================================================
    // Output flops
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            RDATA_O <= 8'h00;
            PAL_ADDR_O <= 8'h00;
            COLOURS_O <= 96'h0;
            DCLK_SEL_O <= DCLK_PRIMARY;
            LATCH_ON_LATCH_CLOCK_INPUT_O <= 1'b0;
            SYS_BLANK_SEL_O <= 1'b0;
        end else if (CE_I) begin
            RDATA_O <= rdata_next;
            PAL_ADDR_O <= pal_addr;
            COLOURS_O <= colours;
            if (valid_code) begin
                DCLK_SEL_O <= dclk_next;
                LATCH_ON_LATCH_CLOCK_INPUT_O <= latch_clock_input_next;
                SYS_BLANK_SEL_O <= latch_clock_input_next;
            end
        end
    end
endmodule // pics_regs

// ==== pics_regs_chk.sv ====
`timescale 1ns/1ns
module pics_regs_chk
    import pics_pkg::*;
(
    input wire logic MCLK_I, // Clock
    input wire logic RST_I, // Reset
    input wire logic CE_I, // Enable
    input wire logic [3:0] SEL_I, // Select
    input wire logic WR_I, // Write
    input wire logic RD_I, // Read
    input wire logic [7:0] WDATA_I, // Write data
    input wire logic [7:0] PIXEL_I, // Pixel
    input wire logic [1:0] PLANES_I, // Planes
    input wire logic MASK_EN_I, // Mask mode
    input wire logic LATCH_SEL_I, // Latch select
    input wire logic [7:0] RDATA_O, // Read data
    input wire logic [7:0] PAL_ADDR_O, // Palette address
    input wire logic [95:0] COLOURS_O, // Colours
    input wire logic [1:0] DCLK_SEL_O, // Dot clock
    input wire logic LATCH_ON_LATCH_CLOCK_INPUT_O, // Latch clock
    input wire logic SYS_BLANK_SEL_O // Blank select
);
    // ==========================================
    // Cycles since the write strobe was last high
    logic [3:0] idle_reg;
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            idle_reg <= 4'h0;
        end else if (WR_I) begin
            idle_reg <= 4'h0;
        end else if (idle_reg != 4'hf) begin
            idle_reg <= idle_reg + 4'h1;
        end
    end
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    pass_through_a: assert property (!$past(RST_I) && $past(CE_I)
        && $past(!MASK_EN_I) && $past(PLANES_I) == PLANES_8
        |-> PAL_ADDR_O == $past(PIXEL_I))
        else $error("pixel not passed through");
    low_bits_a: assert property (!$past(RST_I) && $past(CE_I)
        && $past(!MASK_EN_I) && $past(PLANES_I) == PLANES_4
        |-> PAL_ADDR_O[3:0] == $past(PIXEL_I[3:0]))
        else $error("low address bits not from pixel");
    mask_and_a: assert property (!$past(RST_I) && $past(CE_I)
        && $past(MASK_EN_I) && $past(PLANES_I) == PLANES_8
        |-> (PAL_ADDR_O & ~$past(PIXEL_I)) == 8'h00)
        else $error("masked address sets bit");
    same_latch_a: assert property (SYS_BLANK_SEL_O == LATCH_ON_LATCH_CLOCK_INPUT_O)
        else $error("blank and port latch differ");
    no_code_a: assert property (DCLK_SEL_O != 2'h3)
        else $error("bad dot clock select");
    quiet_hold_a: assert property (idle_reg >= 4'h6
        |-> $stable(COLOURS_O) && $stable(DCLK_SEL_O))
        else $error("state changed without write");
    refused_rd_a: assert property (!$past(RST_I) && $past(CE_I)
        && $past(SEL_I) == 4'h6 |-> RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    reset_val_a: assert property ($fell(RST_I)
        |-> DCLK_SEL_O == DCLK_PRIMARY && !LATCH_ON_LATCH_CLOCK_INPUT_O)
        else $error("bad clock reset value");
    cover property ($rose(WR_I));
    cover property ($fell(RD_I) && SEL_I == SEL_COLOUR_PORT);
    cover property (DCLK_SEL_O == DCLK_SYNTH);
endmodule // pics_regs_chk
bind pics_regs pics_regs_chk pics_regs_chk_i (.MCLK_I(MCLK_I), .RST_I(RST_I),
    .CE_I(CE_I), .SEL_I(SEL_I), .WR_I(WR_I), .RD_I(RD_I), .WDATA_I(WDATA_I),
    .PIXEL_I(PIXEL_I), .PLANES_I(PLANES_I), .MASK_EN_I(MASK_EN_I),
    .LATCH_SEL_I(LATCH_SEL_I), .RDATA_O(RDATA_O), .PAL_ADDR_O(PAL_ADDR_O),
    .COLOURS_O(COLOURS_O), .DCLK_SEL_O(DCLK_SEL_O),
    .LATCH_ON_LATCH_CLOCK_INPUT_O(LATCH_ON_LATCH_CLOCK_INPUT_O), .SYS_BLANK_SEL_O(SYS_BLANK_SEL_O));

// ==== test_pics_regs.sv ====
`timescale 1ns/1ns
module test_pics_regs;
    import pics_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, mask_en = 1'b0, latch_sel = 1'b0;
    logic ce = 1'b1;
    logic [1:0] planes = 2'h0;
    logic [7:0] pixel = 8'h00;
    logic [3:0] sel;
    logic wr, rd, latch_clock_input, system_blank_input;
    logic [7:0] wdata, rdata, pal;
    logic [95:0] colours;
    logic [1:0] dclk;
    int n_fail = 0, n_tests = 0;
    logic [3:0] code [5] = '{4'h0, 4'h5, 4'h3, 4'h6, 4'h7};
    pics_dclk_t want [5] = '{DCLK_PRIMARY, DCLK_SYNTH, DCLK_SYNTH, DCLK_STOP,
        DCLK_PRIMARY};
    always #4 mclk = ~mclk;
    pics_regs pics_regs_i (.MCLK_I(mclk), .RST_I(rst), .CE_I(ce),
        .SEL_I(sel), .WR_I(wr), .RD_I(rd), .WDATA_I(wdata), .PIXEL_I(pixel),
        .PLANES_I(planes), .MASK_EN_I(mask_en), .LATCH_SEL_I(latch_sel),
        .RDATA_O(rdata), .PAL_ADDR_O(pal), .COLOURS_O(colours),
        .DCLK_SEL_O(dclk), .LATCH_ON_LATCH_CLOCK_INPUT_O(latch_clock_input), .SYS_BLANK_SEL_O(system_blank_input));
    pics_host pics_host_i (.clk_i(mclk), .rdata_i(rdata), .sel_o(sel),
        .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
    // ==========================================
    task automatic chk(input string nm, input logic [95:0] s, e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic wi(input logic [7:0] idx, d);
        pics_host_i.wr(SEL_INDEX_ADDR, idx);
        pics_host_i.wr(SEL_INDEX_DATA, d);
    endtask
    task automatic ri(input logic [7:0] idx, output logic [7:0] d);
        pics_host_i.wr(SEL_INDEX_ADDR, idx);
        pics_host_i.rd(SEL_INDEX_DATA, d);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        logic [7:0] b;
        logic [95:0] exp;
        logic [1:0] r;
        int p;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        ri(IDX_CLOCK_SOURCE, b);
        chk("clock src", b, RST_CLOCK_SOURCE);
        chk("dclk", dclk, DCLK_PRIMARY);
        $display("test reset done");
        // Start at cursor 3 so the pointer has to wrap
        exp = '0;
        pics_host_i.wr(SEL_COLOUR_WPTR, 8'h03);
        for (int k = 0; k < 12; k++) begin
            r = 2'(3 + k / 3);
            exp[r * 24 + 16 - 8 * (k % 3) +: 8] = 8'h10 + 8'(k);
            pics_host_i.wr(SEL_COLOUR_PORT, 8'h10 + 8'(k));
        end
        chk("colours", colours, exp);
        pics_host_i.wr(SEL_COLOUR_RPTR, 8'h01);
        for (int k = 0; k < 12; k++) begin
            r = 2'(1 + k / 3);
            p = r * 24 + 16 - 8 * (k % 3);
            pics_host_i.rd(SEL_COLOUR_PORT, b);
            chk("byte", b, exp[p +: 8]);
        end
        $display("test colours done");
        pics_host_i.wr(SEL_PLANE_MASK, 8'h5a);
        wi(IDX_LOOKUP_PAGE, 8'hc3);
        // Mixed pixel bits so a one in the mask must pass a zero too
        pixel = 8'h96;
        for (int i = 0; i < 8; i++) begin
            mask_en = (i < 4);
            planes = 2'(i);
            b = (i % 4 == 0) ? 8'hff : 8'hff >> (8 >> (i % 4));
            b = (pixel & (mask_en ? 8'h5a : 8'hff) & b) | (8'hc3 & ~b);
            repeat (2) @(negedge mclk);
            chk("pal", pal, b);
        end
        mask_en = 1'b0;
        planes = PLANES_8;
        repeat (2) @(negedge mclk);
        chk("pal open", pal, pixel);
        // A write while the enable is low must leave the mask alone
        ce = 1'b0;
        pics_host_i.wr(SEL_PLANE_MASK, 8'h00);
        ce = 1'b1;
        pics_host_i.rd(SEL_PLANE_MASK, b);
        chk("mask held", b, 8'h5a);
        $display("test address done");
        for (int i = 0; i < 5; i++) begin
            latch_sel = (code[i] == CSRC_PRI_LATCH);
            wi(IDX_CLOCK_SOURCE, {4'h0, code[i]});
            chk("dclk", dclk, want[i]);
            if (code[i] == CSRC_PRI_LATCH || code[i] == CSRC_PRI_PRI) begin
                chk("latch", {latch_clock_input, system_blank_input}, {2{latch_sel}});
            end
            ri(IDX_CLOCK_SOURCE, b);
            chk("src back", b, {4'h0, code[i]});
        end
        $display("test clock done");
        stop_test();
    end
endmodule // test_pics_regs
